// ### core/associative_translation_lookup.sv
// Purpose: fully associative page translation lookup for the core
// Assumes: core presents one access per cycle with its mapped flag
// Notes:   answer is registered, one cycle after the request
//
// What this block does
// RULE_01 - fixed pages: 4K, low 12 bits pass
// RULE_02 - size select picks 4K to 16M
// RULE_03 - depth 64 single, 16 or 48 pairs; the check here accepts any depth 1 to 64, paired or not
// RULE_04 - all entry keys compared in parallel
// RULE_05 - matching entry supplies its data
// RULE_06 - 32-bit mode: page number 20 to 8
// RULE_07 - 64-bit mode: page number 28 to 16
// RULE_08 - pairs store halved 27-bit page number
// RULE_09 - current tag from key register joins key
// RULE_10 - foreign tag entry never matches
// RULE_11 - only mapped accesses looked up; rest bypass
// RULE_12 - all-tasks entry ignores tag compare
// RULE_13 - frame number replaces page number bits
// RULE_14 - unusable or unwritable store traps
// RULE_15 - no match raises refill trap
// RULE_16 - bit above offset picks even/odd half
//
// Chosen here: the register addresses and strobed register access.
`include "atl_consts.svh"

module associative_translation_lookup
#(
  parameter int ENTRIES  = 48,
  parameter int PAIRED   = 1,
  parameter int TAG_W    = 8,
  parameter int VAR_PAGE = 1
)
(
  // clock, reset, enable
  input  wire  logic                   clk,
  input  wire  logic                   rst_n,
  input  wire  logic                   ce,
  // register port
  input  wire  logic [`RADDR_W-1:0]    reg_addr,
  input  wire  logic [`RDATA_W-1:0]    reg_wdata,
  input  wire  logic                   reg_we,
  input  wire  logic                   reg_re,
  output logic       [`RDATA_W-1:0]    reg_rdata,
  // lookup request
  input  wire  logic                   req_valid,
  input  wire  atl_pkg::vaddr_t        req_addr,
  input  wire  atl_pkg::access_t       req_kind,
  input  wire  logic                   req_mapped,
  // lookup answer
  output logic                         rsp_valid,
  output atl_pkg::paddr_t              rsp_paddr,
  output logic                         rsp_hit,
  output logic                         rsp_bypass,
  output logic                         rsp_refill,
  output logic                         rsp_unusable,
  output logic                         rsp_store_fault,
  // interrupt
  output logic                         irq
);
  import atl_pkg::*;

  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int KEY_W = `PN_W - PAIRED;

  // every check below runs on the core clock, off during reset
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------------------
  // configuration check
  // --------------------------------------------------------------------------
  // depth, pairing, tag width and variable page are the configuration choices [RULE_03]
  if (ENTRIES < 1 || ENTRIES > 64 || PAIRED < 0 || PAIRED > 1 ||
      TAG_W < 1 || TAG_W > 8 || VAR_PAGE < 0 || VAR_PAGE > 1)
  begin : g_bad_cfg
    $error("unsupported lookup configuration");
  end

  // low bits of the 4K page number left out of compare or offset
  function automatic logic [`PN_W-1:0] page_mask(input size_code_t sz,
                                                 input logic       pair);
    logic [5:0] n;
    n = {2'h0, sz, 1'b0} + {5'h0, pair};
    page_mask = (`PN_W'(1) << n) - `PN_W'(1);
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [TAG_W-1:0]    key_tag_r, key_tag_nxt;
  logic [`PN_W-1:0]    vpn_r, vpn_nxt;
  size_code_t          size_r, size_nxt;
  logic [`RDATA_W-1:0] even_r, even_nxt;
  logic [`RDATA_W-1:0] odd_r, odd_nxt;
  logic [IDX_W-1:0]    index_r, index_nxt;
  logic                addr64_r, addr64_nxt;
  logic [`EV_W-1:0]    status_r, status_nxt;
  logic [`EV_W-1:0]    mask_r, mask_nxt;
  logic [`RDATA_W-1:0] rdata_nxt;
  logic                irq_nxt;
  logic                ent_live_r[ENTRIES], ent_live_nxt[ENTRIES];
  logic [KEY_W-1:0]    ent_key_r[ENTRIES], ent_key_nxt[ENTRIES];
  logic [TAG_W-1:0]    ent_tag_r[ENTRIES], ent_tag_nxt[ENTRIES];
  logic                ent_glb_r[ENTRIES], ent_glb_nxt[ENTRIES];
  size_code_t          ent_size_r[ENTRIES], ent_size_nxt[ENTRIES];
  logic [`RDATA_W-1:0] ent_even_r[ENTRIES], ent_even_nxt[ENTRIES];
  logic [`RDATA_W-1:0] ent_odd_r[ENTRIES], ent_odd_nxt[ENTRIES];
  logic                valid_nxt, hit_nxt, bypass_nxt;
  logic                refill_nxt, unusable_nxt, store_nxt;
  paddr_t              paddr_nxt;

  // --------------------------------------------------------------------------
  // parallel key compare
  // --------------------------------------------------------------------------
  vaddr_t              va_eff;
  logic [`PN_W-1:0]    va_pn;
  logic [ENTRIES-1:0]  match_vec;

  // 32-bit mode drops the upper bits: 20..8 bit pages [RULE_06]
  // 64-bit mode keeps 28..16 bit page numbers [RULE_07]
  assign va_eff = addr64_r ? req_addr
                           : {{(`VA_W-`VA32_W){1'b0}}, req_addr[`VA32_W-1:0]};
  assign va_pn  = va_eff[`VA_W-1:`PAGE_OFS];

  // every entry compared at once, no index restriction [RULE_04]
  for (genvar gi = 0; gi < ENTRIES; gi++)
  begin : g_cmp
    logic [`PN_W-1:0] ign;
    logic             pn_eq;
    logic             tag_ok;
    assign ign    = page_mask(ent_size_r[gi], PAIRED[0]); // [RULE_02]
    // stored pair key is page number halved [RULE_08]
    assign pn_eq  = ((va_pn[`PN_W-1:PAIRED] ^ ent_key_r[gi]) &
                     ~ign[`PN_W-1:PAIRED]) == '0;
    // foreign tag ignored unless entry is for all tasks [RULE_10] [RULE_12]
    assign tag_ok = ent_glb_r[gi] || (ent_tag_r[gi] == key_tag_r);
    assign match_vec[gi] = ent_live_r[gi] && pn_eq && tag_ok;

    tag_gate_a: assert property // [RULE_10]
      (match_vec[gi] |-> (ent_glb_r[gi] || ent_tag_r[gi] == key_tag_r))
      else $error("entry matched with foreign tag");
  end

  // --------------------------------------------------------------------------
  // match select and address forming
  // --------------------------------------------------------------------------
  logic                sel_found;
  logic [IDX_W-1:0]    sel_idx;
  size_code_t          sel_size;
  logic [`PN_W-1:0]    off_pn;
  logic                sel_odd;
  logic [`RDATA_W-1:0] sel_data;
  logic [`PA_W-1:0]    off_pa;
  logic [`PA_W-1:0]    frame_pa;

  // lowest index wins if software left duplicates
  always_comb
  begin
    sel_found = 1'b0;
    sel_idx   = '0;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (match_vec[i] && !sel_found)
      begin
        sel_found = 1'b1;
        sel_idx   = i[IDX_W-1:0];
      end
    end
  end

  // matched entry data, half chosen by bit above offset [RULE_05] [RULE_16]
  assign sel_size = ent_size_r[sel_idx];
  assign off_pn   = page_mask(sel_size, 1'b0);
  assign sel_odd  = (PAIRED == 1) &&
                    ((va_pn & (page_mask(sel_size, 1'b1) ^ off_pn)) != '0);
  assign sel_data = sel_odd ? ent_odd_r[sel_idx] : ent_even_r[sel_idx];
  // frame number replaces page bits, offset kept [RULE_13] [RULE_01]
  assign off_pa   = {off_pn[`PFN_W-1:0], `OFS_ONES};
  assign frame_pa = {sel_data[`DAT_PFN_HI:`DAT_PFN_LO], `PAGE_OFS'(0)};

  // answer next values
  always_comb
  begin
    logic usable;
    logic perm;
    usable       = sel_data[`DAT_USABLE];
    perm         = sel_data[`DAT_STORE];
    valid_nxt    = req_valid;
    // unmapped accesses skip the translator [RULE_11]
    bypass_nxt   = req_valid && !req_mapped;
    // no matching entry: refill trap [RULE_15]
    refill_nxt   = req_valid && req_mapped && !sel_found;
    // unusable entry or store without permit traps [RULE_14]
    unusable_nxt = req_valid && req_mapped && sel_found && !usable;
    store_nxt    = req_valid && req_mapped && sel_found && usable &&
                   (req_kind == ACC_STORE) && !perm;
    hit_nxt      = req_valid && req_mapped && sel_found && usable &&
                   !((req_kind == ACC_STORE) && !perm);
    if (bypass_nxt)
      paddr_nxt = va_eff[`PA_W-1:0];
    else if (hit_nxt)
      paddr_nxt = (frame_pa & ~off_pa) | (va_eff[`PA_W-1:0] & off_pa);
    else
      paddr_nxt = '0;
  end

  // --------------------------------------------------------------------------
  // register port, entry writes and events
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [`EV_W-1:0] events;
    logic [`EV_W-1:0] w1c;
    w1c          = '0;
    events       = {store_nxt, unusable_nxt, refill_nxt};
    key_tag_nxt  = key_tag_r;
    vpn_nxt      = vpn_r;
    size_nxt     = size_r;
    even_nxt     = even_r;
    odd_nxt      = odd_r;
    index_nxt    = index_r;
    addr64_nxt   = addr64_r;
    mask_nxt     = mask_r;
    ent_live_nxt = ent_live_r;
    ent_key_nxt  = ent_key_r;
    ent_tag_nxt  = ent_tag_r;
    ent_glb_nxt  = ent_glb_r;
    ent_size_nxt = ent_size_r;
    ent_even_nxt = ent_even_r;
    ent_odd_nxt  = ent_odd_r;
    if (reg_we)
    begin
      case (reg_addr)
        // current tag lives in the key register [RULE_09]
        `OFS_KEY:    key_tag_nxt = reg_wdata[TAG_W-1:0];
        `OFS_VPN:    vpn_nxt     = reg_wdata[`PN_W-1:0];
        // codes above 16M clamp to 16M [RULE_02]
        `OFS_SIZE:   size_nxt    = (reg_wdata[`SIZE_W-1:0] > `SIZE_MAX) ?
                                   `SIZE_MAX : reg_wdata[`SIZE_W-1:0];
        `OFS_EVEN:   even_nxt    = reg_wdata;
        `OFS_ODD:    odd_nxt     = reg_wdata;
        `OFS_INDEX:  index_nxt   = reg_wdata[IDX_W-1:0];
        `OFS_CTRL:   addr64_nxt  = reg_wdata[`CTRL_ADDR64];
        `OFS_STATUS: w1c         = reg_wdata[`EV_W-1:0];
        `OFS_MASK:   mask_nxt    = reg_wdata[`EV_W-1:0];
        `OFS_CMD:
        begin
          if (reg_wdata[`CMD_COMMIT] && (int'(index_r) < ENTRIES))
          begin
            ent_live_nxt[index_r] = 1'b1;
            ent_key_nxt[index_r]  = vpn_r[KEY_W-1:0]; // [RULE_08]
            ent_tag_nxt[index_r]  = key_tag_r;
            ent_glb_nxt[index_r]  = even_r[`DAT_GLOBAL] &&
                                    ((PAIRED == 0) || odd_r[`DAT_GLOBAL]);
            // fixed build holds every entry at 4K [RULE_01]
            ent_size_nxt[index_r] = (VAR_PAGE == 1) ? size_r : '0;
            ent_even_nxt[index_r] = even_r;
            ent_odd_nxt[index_r]  = odd_r;
          end
        end
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    status_nxt = (status_r & ~w1c) | events;
    irq_nxt    = |(status_nxt & mask_nxt);
    rdata_nxt  = `RST_WORD;
    if (reg_re)
    begin
      case (reg_addr)
        `OFS_KEY:    rdata_nxt = {{(`RDATA_W-TAG_W){1'b0}}, key_tag_r};
        `OFS_VPN:    rdata_nxt = {{(`RDATA_W-`PN_W){1'b0}}, vpn_r};
        `OFS_SIZE:   rdata_nxt = {{(`RDATA_W-`SIZE_W){1'b0}}, size_r};
        `OFS_EVEN:   rdata_nxt = even_r;
        `OFS_ODD:    rdata_nxt = odd_r;
        `OFS_INDEX:  rdata_nxt = {{(`RDATA_W-IDX_W){1'b0}}, index_r};
        `OFS_CTRL:   rdata_nxt = {{(`RDATA_W-1){1'b0}}, addr64_r};
        `OFS_STATUS: rdata_nxt = {{(`RDATA_W-`EV_W){1'b0}}, status_r};
        `OFS_MASK:   rdata_nxt = {{(`RDATA_W-`EV_W){1'b0}}, mask_r};
        default:     rdata_nxt = `RST_WORD;
      endcase
    end
  end

  // registers, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      key_tag_r       <= '0;
      vpn_r           <= '0;
      size_r          <= '0;
      even_r          <= `RST_WORD;
      odd_r           <= `RST_WORD;
      index_r         <= '0;
      addr64_r        <= 1'b0;
      status_r        <= '0;
      mask_r          <= '0;
      reg_rdata       <= `RST_WORD;
      irq             <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_paddr       <= '0;
      rsp_hit         <= 1'b0;
      rsp_bypass      <= 1'b0;
      rsp_refill      <= 1'b0;
      rsp_unusable    <= 1'b0;
      rsp_store_fault <= 1'b0;
      for (int i = 0; i < ENTRIES; i++)
      begin
        ent_live_r[i] <= 1'b0;
        ent_key_r[i]  <= '0;
        ent_tag_r[i]  <= '0;
        ent_glb_r[i]  <= 1'b0;
        ent_size_r[i] <= '0;
        ent_even_r[i] <= `RST_WORD;
        ent_odd_r[i]  <= `RST_WORD;
      end
    end
    else if (ce)
    begin
      key_tag_r       <= key_tag_nxt;
      vpn_r           <= vpn_nxt;
      size_r          <= size_nxt;
      even_r          <= even_nxt;
      odd_r           <= odd_nxt;
      index_r         <= index_nxt;
      addr64_r        <= addr64_nxt;
      status_r        <= status_nxt;
      mask_r          <= mask_nxt;
      reg_rdata       <= rdata_nxt;
      irq             <= irq_nxt;
      rsp_valid       <= valid_nxt;
      rsp_paddr       <= paddr_nxt;
      rsp_hit         <= hit_nxt;
      rsp_bypass      <= bypass_nxt;
      rsp_refill      <= refill_nxt;
      rsp_unusable    <= unusable_nxt;
      rsp_store_fault <= store_nxt;
      ent_live_r      <= ent_live_nxt;
      ent_key_r       <= ent_key_nxt;
      ent_tag_r       <= ent_tag_nxt;
      ent_glb_r       <= ent_glb_nxt;
      ent_size_r      <= ent_size_nxt;
      ent_even_r      <= ent_even_nxt;
      ent_odd_r       <= ent_odd_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  answer_follows_a: assert property // [RULE_05]
    ((ce && req_valid) |=> rsp_valid)
    else $error("request without answer");
  bypass_only_a: assert property // [RULE_11]
    ((ce && req_valid && !req_mapped) |=>
      (rsp_bypass && !rsp_refill && !rsp_unusable && !rsp_store_fault))
    else $error("unmapped access was looked up");
  bypass_addr_a: assert property // [RULE_11]
    ((ce && req_valid && !req_mapped && addr64_r) |=>
      (rsp_paddr == $past(req_addr[`PA_W-1:0])))
    else $error("bypass address altered");
  offset_kept_a: assert property // [RULE_01]
    ((ce && hit_nxt) |=>
      (rsp_paddr[`PAGE_OFS-1:0] == $past(req_addr[`PAGE_OFS-1:0])))
    else $error("page offset not kept");
  frame_used_a: assert property // [RULE_13]
    ((ce && hit_nxt && sel_size == '0) |=>
      (rsp_paddr[`PA_W-1:`PAGE_OFS] ==
       $past(sel_data[`DAT_PFN_HI:`DAT_PFN_LO])))
    else $error("frame number not used");
  refill_miss_a: assert property // [RULE_15]
    ((ce && req_valid && req_mapped && match_vec == '0) |=>
      (rsp_refill && !rsp_hit))
    else $error("miss without refill trap");
  store_trap_a: assert property // [RULE_14]
    ($rose(rsp_store_fault) |-> ($past(req_kind) == ACC_STORE))
    else $error("store trap on non-store");
  irq_level_a: assert property
    (ce |=> (irq == |(status_r & mask_r)))
    else $error("interrupt level wrong");

  hit_seen_c:     cover property (rsp_hit);
  refill_seen_c:  cover property (rsp_refill);
  store_seen_c:   cover property (rsp_store_fault);
  odd_half_c:     cover property (ce && hit_nxt && sel_odd);

endmodule

// ### core/atl_consts.svh
// Purpose: named offsets, field positions and widths of the lookup block
// Assumes: included by the package and the lookup module
// Notes:   register offsets are byte addresses on the plain register port
`ifndef ATL_CONSTS_SVH
`define ATL_CONSTS_SVH

// --------------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------------
`define OFS_KEY     8'h00
`define OFS_VPN     8'h04
`define OFS_SIZE    8'h08
`define OFS_EVEN    8'h0c
`define OFS_ODD     8'h10
`define OFS_INDEX   8'h14
`define OFS_CMD     8'h18
`define OFS_CTRL    8'h1c
`define OFS_STATUS  8'h20
`define OFS_MASK    8'h24

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define DAT_GLOBAL  0
`define DAT_USABLE  1
`define DAT_STORE   2
`define DAT_PFN_LO  8
`define DAT_PFN_HI  31
`define CMD_COMMIT  0
`define CTRL_ADDR64 0
`define EV_REFILL   0
`define EV_UNUSABLE 1
`define EV_STORE    2

// --------------------------------------------------------------------------
// widths and reset values
// --------------------------------------------------------------------------
`define EV_W        3
`define RADDR_W     8
`define RDATA_W     32
`define PAGE_OFS    12
`define OFS_ONES    12'hfff
`define SIZE_W      3
`define SIZE_MAX    3'h6
`define VA_W        40
`define VA32_W      32
`define PA_W        36
`define PN_W        28
`define PFN_W       24
`define RST_WORD    32'h0000_0000

`endif

// ### core/atl_pkg.sv
// Purpose: shared types of the translation lookup block
// Assumes: constants come from atl_consts.svh
// Notes:   access kinds follow a gray order fetch, load, store
`include "atl_consts.svh"

package atl_pkg;

  // kind of core access presented for lookup
  typedef enum logic [1:0]
  {
    ACC_FETCH = 2'h0,
    ACC_LOAD  = 2'h1,
    ACC_STORE = 2'h3
  } access_t;

  typedef logic [`SIZE_W-1:0] size_code_t;
  typedef logic [`VA_W-1:0]   vaddr_t;
  typedef logic [`PA_W-1:0]   paddr_t;

endpackage

// ### verif/core_access_model.sv
// Purpose: core side model that issues lookup requests
// Assumes: requests are driven right after a rising clock edge
// Notes:   released lines show the inverse address and mapped flag of the last request
module core_access_model
(
  // clock
  input  wire logic             clk,
  // lookup request
  output logic                  req_valid,
  output atl_pkg::vaddr_t       req_addr,
  output atl_pkg::access_t      req_kind,
  output logic                  req_mapped
);
  timeunit 1ns;
  timeprecision 1ns;
  import atl_pkg::*;

  // quiet lines at time zero
  initial
  begin
    req_valid  = 1'b0;
    req_addr   = '0;
    req_kind   = ACC_FETCH;
    req_mapped = 1'b0;
  end

  // one request, taken at the next edge; mapped flag set by caller
  task automatic issue(input vaddr_t a, input access_t k, input logic m);
    @(posedge clk);
    req_valid  <= 1'b1;
    req_addr   <= a;
    req_kind   <= k;
    req_mapped <= m;
  endtask

  // release: stale address is inverted so it cannot pass for a request
  task automatic idle();
    @(posedge clk);
    req_valid  <= 1'b0;
    req_addr   <= ~req_addr;
    req_mapped <= ~req_mapped;
  endtask
endmodule

// ### verif/associative_translation_lookup_test.sv
// Purpose: self-checking bench of the translation lookup block
// Assumes: default build, 48 paired entries, variable page size
// Notes:   lookup answers are checked from a queue of notes
`include "atl_consts.svh"
module associative_translation_lookup_test;
  timeunit 1ns;
  timeprecision 1ns;
  import atl_pkg::*;

  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  typedef struct packed { logic [4:0] flags; paddr_t pa; } note_t;
  localparam logic [4:0] F_HIT = 5'h10;
  localparam logic [4:0] F_BYP = 5'h08;
  localparam logic [4:0] F_REF = 5'h04;
  localparam logic [4:0] F_UNU = 5'h02;
  localparam logic [4:0] F_STF = 5'h01;
  logic             clk       = 1'b0;
  logic             rst_n     = 1'b0;
  logic             ce        = 1'b1;
  logic [7:0]       reg_addr  = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_we    = 1'b0;
  logic             reg_re    = 1'b0;
  logic [31:0]      reg_rdata;
  logic             req_valid;
  vaddr_t           req_addr;
  access_t          req_kind;
  logic             req_mapped;
  logic             rsp_valid;
  paddr_t           rsp_paddr;
  logic             rsp_hit;
  logic             rsp_bypass;
  logic             rsp_refill;
  logic             rsp_unusable;
  logic             rsp_store_fault;
  logic             irq;
  note_t            expq[$];
  int               num_errors = 0;
  int               compares   = 0;
  logic [31:0]      seed       = 32'h0001_00f7;

  always #50 clk = ~clk;

  associative_translation_lookup associative_translation_lookup_inst
  (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_addr(req_addr), .req_kind(req_kind),
    .req_mapped(req_mapped), .rsp_valid(rsp_valid),
    .rsp_paddr(rsp_paddr), .rsp_hit(rsp_hit), .rsp_bypass(rsp_bypass),
    .rsp_refill(rsp_refill), .rsp_unusable(rsp_unusable),
    .rsp_store_fault(rsp_store_fault), .irq(irq)
  );

  core_access_model core_access_model_inst
  (
    .clk(clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_kind(req_kind), .req_mapped(req_mapped)
  );

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // data word: frame number over permission bits
  function automatic logic [31:0] dw(input logic [23:0] f, input logic [2:0] b);
    return {f, 5'h0, b};
  endfunction

  task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rsp(input note_t got);
    note_t e;
    compares++;
    if (expq.size() == 0)
    begin
      num_errors++;
      $display("[FAIL] %0t answer with no request pending", $time);
    end
    else
    begin
      e = expq.pop_front();
      if (got !== e)
      begin
        num_errors++;
        $display("[FAIL] %0t answer %h expected %h", $time, got, e);
      end
    end
  endtask

  // answers are sampled one edge after they are registered
  always @(posedge clk)
    if (rsp_valid === 1'b1)
      check_rsp({rsp_hit, rsp_bypass, rsp_refill, rsp_unusable,
                 rsp_store_fault, rsp_paddr});

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1;
    check_word({4'h0, reg_rdata}, {4'h0, e});
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    check_word({35'h0, irq}, {35'h0, e});
  endtask

  task automatic wr_entry(input int idx, input logic [7:0] tag,
                          input vaddr_t va, input logic [2:0] sz,
                          input logic [31:0] ev, input logic [31:0] od);
    reg_wr(`OFS_KEY, {24'h0, tag});
    reg_wr(`OFS_VPN, {5'h0, va[39:13]});
    reg_wr(`OFS_SIZE, {29'h0, sz});
    reg_wr(`OFS_EVEN, ev);
    reg_wr(`OFS_ODD, od);
    reg_wr(`OFS_INDEX, idx);
    reg_wr(`OFS_CMD, 32'h1);
  endtask

  task automatic look(input vaddr_t va, input access_t k, input logic m,
                      input logic [4:0] f, input paddr_t pa);
    expq.push_back({f, pa});
    core_access_model_inst.issue(va, k, m);
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(5000 * 100);
    num_errors++;
    final_report();
  end

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial
  begin
    vaddr_t           va;
    paddr_t           msk;
    logic [23:0]      pe;
    logic [23:0]      po;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // empty buffer: refill, event and interrupt
    look({8'h0, rnd()}, ACC_LOAD, 1'b1, F_REF, '0);
    core_access_model_inst.idle();
    chk_rd(`OFS_STATUS, 32'h1);
    reg_wr(`OFS_MASK, 32'h7);
    chk_irq(1'b1);
    // writes are ignored while the block is frozen
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(`OFS_MASK, 32'h0);
    ce <= 1'b1;
    chk_irq(1'b1);
    reg_wr(`OFS_STATUS, 32'h7);
    chk_irq(1'b0);
    chk_rd(8'h30, 32'h0);
    reg_wr(`OFS_SIZE, 32'h7);
    chk_rd(`OFS_SIZE, 32'h6);
    chk_rd(`OFS_CMD, 32'h0);
    // one pair: both halves, store permit, bypass, back to back
    va = {8'h0, rnd()} & ~40'h1000;
    pe = rnd();
    po = rnd();
    wr_entry(5, 8'h12, va, 3'h0, dw(pe, 3'h6), dw(po, 3'h2));
    look(va, ACC_LOAD, 1'b1, F_HIT, {pe, va[11:0]});
    look(va | 40'h1000, ACC_FETCH, 1'b1, F_HIT, {po, va[11:0]});
    look(va | 40'h1000, ACC_STORE, 1'b1, F_STF, '0);
    look(va, ACC_STORE, 1'b1, F_HIT, {pe, va[11:0]});
    look({8'hab, va[31:0]}, ACC_STORE, 1'b0, F_BYP,
         {4'h0, va[31:0]});
    core_access_model_inst.idle();
    // foreign tag, all-tasks entry, unusable entry
    reg_wr(`OFS_KEY, 32'h34);
    look(va, ACC_LOAD, 1'b1, F_REF, '0);
    core_access_model_inst.idle();
    va = {8'h0, rnd()};
    wr_entry(6, 8'h56, va, 3'h0, dw(pe, 3'h7), dw(po, 3'h7));
    reg_wr(`OFS_KEY, 32'h34);
    look(va, ACC_LOAD, 1'b1, F_HIT,
         {va[12] ? po : pe, va[11:0]});
    core_access_model_inst.idle();
    va = {8'h0, rnd()};
    wr_entry(7, 8'h34, va, 3'h0, dw(pe, 3'h4), dw(po, 3'h4));
    look(va, ACC_STORE, 1'b1, F_UNU, '0);
    core_access_model_inst.idle();
    chk_rd(`OFS_STATUS, 32'h7);
    // every page size, and the first compared bit above the page
    for (int s = 0; s < 7; s++)
    begin
      va = {8'h0, rnd()};
      pe = rnd();
      po = rnd();
      msk = (36'h1 << (12 + 2 * s)) - 36'h1;
      // own tag per size, so large pages cannot shadow later lookups
      wr_entry(10 + s, {5'h08, s[2:0]}, va, s[2:0],
               dw(pe, 3'h2), dw(po, 3'h2));
      look(va, ACC_FETCH, 1'b1, F_HIT,
           ({va[12 + 2 * s] ? po : pe, 12'h0} & ~msk)
           | (va[35:0] & msk));
      look(va ^ (40'h1 << (13 + 2 * s)), ACC_LOAD, 1'b1, F_REF,
           '0);
      core_access_model_inst.idle();
    end
    // wide addresses in the last entry
    reg_wr(`OFS_CTRL, 32'h1);
    va = {8'h9c, rnd()};
    wr_entry(47, 8'h34, va, 3'h0, dw(pe, 3'h2), dw(po, 3'h2));
    look(va, ACC_LOAD, 1'b1, F_HIT,
         {va[12] ? po : pe, va[11:0]});
    look(va, ACC_LOAD, 1'b0, F_BYP, va[35:0]);
    core_access_model_inst.idle();
    reg_wr(`OFS_CTRL, 32'h0);
    look(va, ACC_LOAD, 1'b1, F_REF, '0);
    core_access_model_inst.idle();
    repeat (3) @(posedge clk);
    check_word(36'(expq.size()), 36'h0);
    final_report();
  end
endmodule
